// >>> dv/pscl_host_model.sv
// Host processor model on the serial host port of pscl_regs.
// Assumes sclk high for five and low for eleven system clocks, and 16-bit frames.
`timescale 1ns/100ps
`default_nettype none
module pscl_host_model
(
	input wire logic clk_sys_i,
	input wire logic sdo_i,
	input wire logic sdo_oe_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic sdi_o
);
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end
	// Sclk stands low between frames; sdi then shows the inverse of its last bit
	task automatic frame(input logic [15:0] bits, output logic [7:0] rd);
		for (int i = 15; i >= 0; i--)
		begin
			@(posedge clk_sys_i) cs_n_o <= 1'b0;
			sdi_o <= bits[i];
			repeat (5) @(posedge clk_sys_i);
			sclk_o <= 1'b1;
			repeat (5) @(posedge clk_sys_i);
			sclk_o <= 1'b0;
			repeat (5) @(posedge clk_sys_i);
			// Data bit k leaves on the fall that closes header/data bit k+1
			if (i >= 1 && i <= 8)
				rd[i-1] = sdo_oe_i ? sdo_i : 1'bx;
		end
		cs_n_o <= 1'b1;
		sdi_o <= ~sdi_o;
		repeat (8) @(posedge clk_sys_i);
	endtask : frame
endmodule : pscl_host_model
`default_nettype wire

// >>> dv/pscl_regs_props.sv
// Checker for the segment sequencer at the pscl_regs ports.
// Assumes one clock domain; bound to every pscl_regs instance.
`timescale 1ns/100ps
`default_nettype none
module pscl_regs_chk
	import pscl_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic arb_mode_i,
	input wire logic pulse_start_i,
	input wire logic seg_tick_i,
	input wire logic [6*PSCL_AMP_W-1:0] seg3_to_8_i,
	input wire logic [PSCL_AMP_W-1:0] seg1_amplitude_o,
	input wire logic [PSCL_AMP_W-1:0] seg2_amplitude_o,
	input wire logic arb_active_o,
	input wire logic [2:0] seg_index_o,
	input wire logic [PSCL_AMP_W-1:0] seg_amp_o,
	input wire logic seg_sign_o,
	input wire logic [PSCL_AMP_W-2:0] seg_mag_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	wire run = arb_active_o && arb_mode_i;
	start_seg_a:
		assert property (!arb_active_o && pulse_start_i && arb_mode_i
			|=> arb_active_o && seg_index_o == 3'h0) else $error("start not taken");
	last_seg_a:
		assert property (run && seg_tick_i && seg_index_o == PSCL_LAST_SEG
			|=> !arb_active_o) else $error("no idle after last segment");
	seg_step_a:
		assert property (run && seg_tick_i && seg_index_o != PSCL_LAST_SEG
			|=> arb_active_o && seg_index_o == $past(seg_index_o) + 3'h1) else $error("bad step");
	seg_hold_a:
		assert property (run && !seg_tick_i |=> $stable(seg_index_o)) else $error("segment moved");
	idle_amp_a:
		assert property (!arb_active_o |=> seg_amp_o == '0) else $error("amplitude while idle");
	mode_abort_a:
		assert property (!arb_mode_i |=> !arb_active_o) else $error("runs without mode");
	seg1_amp_a:
		assert property (run && seg_index_o == 3'h0
			|=> seg_amp_o == $past(seg1_amplitude_o)) else $error("segment one amplitude");
	seg2_amp_a:
		assert property (run && seg_index_o == 3'h1
			|=> seg_amp_o == $past(seg2_amplitude_o)) else $error("segment two amplitude");
	seg3_amp_a:
		assert property (run && seg_index_o == 3'h2
			|=> seg_amp_o == $past(seg3_to_8_i[6:0])) else $error("segment three amplitude");
	sign_split_a:
		assert property (seg_sign_o == seg_amp_o[PSCL_AMP_SIGN]
			&& seg_mag_o == seg_amp_o[5:0]) else $error("sign split wrong");
endmodule : pscl_regs_chk
bind pscl_regs pscl_regs_chk i_pscl_regs_chk (.clk_sys_i, .reset_i, .arb_mode_i,
	.pulse_start_i, .seg_tick_i, .seg3_to_8_i, .seg1_amplitude_o, .seg2_amplitude_o,
	.arb_active_o, .seg_index_o, .seg_amp_o, .seg_sign_o, .seg_mag_o);
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for pscl_regs with a host model on the serial port.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none
module tb import pscl_pkg::*;;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, arb_mode_i = 1'b0, pulse_start_i = 1'b0;
	logic seg_tick_i = 1'b0, cs_n, sclk, sdi, sdo, sdo_oe, arb_active_o, seg_sign_o;
	logic [5:0] cable_loss_estimate_i = 6'h00;
	logic [41:0] seg3_to_8_i = 42'h000;
	logic [6:0] seg1_amplitude_o, seg2_amplitude_o, seg_amp_o;
	logic [5:0] seg_mag_o;
	logic [2:0] seg_index_o;
	logic [7:0] rd;
	int errors = 0, cmp_count = 0;
	initial forever #25 clk_sys_i = ~clk_sys_i;
	pscl_regs i_pscl_regs (.clk_sys_i, .reset_i, .host_cs_n_i(cs_n), .host_sclk_i(sclk),
		.host_sdi_i(sdi), .host_sdo_o(sdo), .host_sdo_oe_o(sdo_oe), .cable_loss_estimate_i,
		.arb_mode_i, .pulse_start_i, .seg_tick_i, .seg3_to_8_i, .seg1_amplitude_o,
		.seg2_amplitude_o, .arb_active_o, .seg_index_o, .seg_amp_o, .seg_sign_o, .seg_mag_o);
	pscl_host_model i_pscl_host_model (.clk_sys_i, .sdo_i(sdo), .sdo_oe_i(sdo_oe),
		.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic test_done();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task automatic acc(input logic r, input logic [4:0] a, input logic [7:0] d);
		i_pscl_host_model.frame({r, a, 2'b00, d}, rd);
	endtask : acc
	task automatic t_regs();
		for (int a = 7; a < 10; a++)
		begin
			acc(1'b1, a[4:0], 8'h00);
			chk(rd, 8'h00);
		end
		acc(1'b0, PSCL_ADDR_SEG1, 8'hD5);
		acc(1'b0, PSCL_ADDR_SEG2, 8'h2A);
		acc(1'b0, PSCL_ADDR_CABLE_LOSS, 8'hFF);
		cable_loss_estimate_i <= 6'h31;
		acc(1'b1, PSCL_ADDR_SEG1, 8'h00);
		chk(rd, 8'hD5);
		chk({1'b0, seg1_amplitude_o}, 8'h55);
		acc(1'b1, PSCL_ADDR_SEG2, 8'h00);
		chk(rd, 8'h2A);
		chk({1'b0, seg2_amplitude_o}, 8'h2A);
		acc(1'b1, PSCL_ADDR_CABLE_LOSS, 8'h00);
		chk(rd, 8'h31);
		acc(1'b1, 5'h1F, 8'h00);
		chk(rd, 8'h00);
		$display("t_regs done");
	endtask : t_regs
	task automatic t_pulse();
		logic [55:0] w;
		w = {42'h2A5_5AA5_C3F0, 7'h2A, 7'h55};
		@(posedge clk_sys_i) arb_mode_i <= 1'b1;
		seg3_to_8_i <= 42'h2A5_5AA5_C3F0;
		pulse_start_i <= 1'b1;
		@(posedge clk_sys_i) pulse_start_i <= 1'b0;
		for (int s = 0; s < 8; s++)
		begin
			repeat (2) @(posedge clk_sys_i);
			#1 chk({1'b0, seg_amp_o}, {1'b0, w[s*7 +: 7]});
			@(posedge clk_sys_i) seg_tick_i <= 1'b1;
			@(posedge clk_sys_i) seg_tick_i <= 1'b0;
		end
		repeat (2) @(posedge clk_sys_i);
		#1 chk({7'h00, arb_active_o}, 8'h00);
		$display("t_pulse done");
	endtask : t_pulse
	task automatic t_abort();
		@(posedge clk_sys_i) pulse_start_i <= 1'b1;
		@(posedge clk_sys_i) pulse_start_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1 chk({7'h00, arb_active_o}, 8'h01);
		chk({1'b0, seg_amp_o}, 8'h55);
		@(posedge clk_sys_i) arb_mode_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1 chk({arb_active_o, seg_amp_o}, 8'h00);
		@(posedge clk_sys_i) pulse_start_i <= 1'b1;
		@(posedge clk_sys_i) pulse_start_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		#1 chk({arb_active_o, seg_amp_o}, 8'h00);
		$display("t_abort done");
	endtask : t_abort
	initial
	begin
		#1000000;
		errors++;
		test_done();
	end
	initial
	begin
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		t_regs();
		t_pulse();
		t_abort();
		test_done();
	end
endmodule : tb
`default_nettype wire

// >>> src/pscl_pkg.sv
// Constants shared by the cable-loss and pulse-segment register slice.
// Assumes one 20 MHz system clock and a serial host port on pins.
// Behaviour
// - Cable loss estimate is six-bit read-only binary
// - Estimate sits in bits five down to zero
// - Arbitrary pulse splits into eight time segments
// - Segment words shape output only in arbitrary mode
// - First segment amplitude from first amplitude word
// - First word is signed magnitude, bit six sign
// - Second segment amplitude from second amplitude word
// - Second word is signed magnitude, bit six sign
// - Third segment word sits at next address
package pscl_pkg;
	// *****************************************
	// Register map
	// *****************************************
	localparam logic [4:0] PSCL_ADDR_CABLE_LOSS = 5'h07;
	localparam logic [4:0] PSCL_ADDR_SEG1 = 5'h08;
	localparam logic [4:0] PSCL_ADDR_SEG2 = 5'h09;
	localparam logic [4:0] PSCL_ADDR_SEG3 = 5'h0A;
	localparam logic [7:0] PSCL_RST_CABLE_LOSS = 8'h00;
	localparam logic [7:0] PSCL_RST_SEG = 8'h00;
	localparam int PSCL_LOSS_W = 6;
	localparam int PSCL_AMP_W = 7;
	localparam int PSCL_AMP_SIGN = 6;
	localparam int PSCL_SEGS = 8;
	localparam logic [2:0] PSCL_LAST_SEG = 3'h7;
	// *****************************************
	// Serial frame layout
	// *****************************************
	localparam int PSCL_RW_BIT = 7;
	localparam int PSCL_ADDR_HI = 6;
	localparam int PSCL_ADDR_LO = 2;
	localparam logic [3:0] PSCL_HDR_LAST = 4'h7;
	localparam logic [3:0] PSCL_FRAME_LAST = 4'hF;
endpackage : pscl_pkg

// >>> src/pscl_regs.sv
// Cable-loss status and pulse segment 1/2 registers behind the serial host port.
// Assumes host pins are asynchronous; equalizer and pulse timing share clk_sys_i.
`timescale 1ns/100ps
`default_nettype none
module pscl_regs
	import pscl_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic host_cs_n_i,
	input wire logic host_sclk_i,
	input wire logic host_sdi_i,
	output logic host_sdo_o,
	output logic host_sdo_oe_o,
	input wire logic [PSCL_LOSS_W-1:0] cable_loss_estimate_i,
	input wire logic arb_mode_i,
	input wire logic pulse_start_i,
	input wire logic seg_tick_i,
	input wire logic [6*PSCL_AMP_W-1:0] seg3_to_8_i,
	output logic [PSCL_AMP_W-1:0] seg1_amplitude_o,
	output logic [PSCL_AMP_W-1:0] seg2_amplitude_o,
	output logic arb_active_o,
	output logic [2:0] seg_index_o,
	output logic [PSCL_AMP_W-1:0] seg_amp_o,
	output logic seg_sign_o,
	output logic [PSCL_AMP_W-2:0] seg_mag_o
);
	logic [2:0] cs_sync_r;
	logic [2:0] sclk_sync_r;
	logic [1:0] sdi_sync_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic [7:0] hdr_r;
	logic [7:0] rd_shift_r;
	logic sdo_r;
	logic [7:0] loss_r;
	logic [7:0] seg1_r;
	logic [7:0] seg2_r;
	logic cs_act;
	logic sclk_rise;
	logic sclk_fall;
	logic rd_phase;
	logic [7:0] hdr_nxt;

	function automatic logic [7:0] pscl_read_mux(input logic [4:0] addr,
		input logic [7:0] loss, input logic [7:0] s1, input logic [7:0] s2);
		case (addr)
			PSCL_ADDR_CABLE_LOSS: pscl_read_mux = loss;
			PSCL_ADDR_SEG1: pscl_read_mux = s1;
			PSCL_ADDR_SEG2: pscl_read_mux = s2;
			default: pscl_read_mux = 8'h00;
		endcase
	endfunction : pscl_read_mux

	// *****************************************
	// Pin synchronisers
	// *****************************************
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cs_sync_r <= 3'h7;
			sclk_sync_r <= 3'h0;
			sdi_sync_r <= 2'h0;
		end
		else
		begin
			cs_sync_r <= {cs_sync_r[1:0], host_cs_n_i};
			sclk_sync_r <= {sclk_sync_r[1:0], host_sclk_i};
			sdi_sync_r <= {sdi_sync_r[0], host_sdi_i};
		end
	end

	assign cs_act = !cs_sync_r[1];
	assign sclk_rise = cs_act && sclk_sync_r[1] && !sclk_sync_r[2];
	assign sclk_fall = cs_act && !sclk_sync_r[1] && sclk_sync_r[2];
	assign hdr_nxt = {shift_r[6:0], sdi_sync_r[1]};
	assign rd_phase = cs_act && hdr_r[PSCL_RW_BIT] && bit_cnt_r[3];

	// *****************************************
	// Serial frame receive
	// *****************************************
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			hdr_r <= 8'h00;
		end
		else if (!cs_act)
		begin
			bit_cnt_r <= 4'h0;
			hdr_r <= 8'h00;
		end
		else if (sclk_rise)
		begin
			bit_cnt_r <= bit_cnt_r + 4'h1;
			shift_r <= hdr_nxt;
			if (bit_cnt_r == PSCL_HDR_LAST)
				hdr_r <= hdr_nxt;
		end
	end

	// *****************************************
	// Read data out
	// *****************************************
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rd_shift_r <= 8'h00;
			sdo_r <= 1'b0;
		end
		else if (sclk_rise && bit_cnt_r == PSCL_HDR_LAST)
			rd_shift_r <= pscl_read_mux(hdr_nxt[PSCL_ADDR_HI:PSCL_ADDR_LO], loss_r, seg1_r, seg2_r);
		else if (sclk_fall && rd_phase)
		begin
			sdo_r <= rd_shift_r[7];
			rd_shift_r <= {rd_shift_r[6:0], 1'b0};
		end
	end

	assign host_sdo_o = sdo_r;
	assign host_sdo_oe_o = rd_phase;

	// *****************************************
	// Registers
	// *****************************************
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			loss_r <= PSCL_RST_CABLE_LOSS;
		else
			loss_r <= {2'b00, cable_loss_estimate_i};
	end

	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			seg1_r <= PSCL_RST_SEG;
			seg2_r <= PSCL_RST_SEG;
		end
		else if (sclk_rise && bit_cnt_r == PSCL_FRAME_LAST && !hdr_r[PSCL_RW_BIT])
		begin
			// Segment 3 onward at PSCL_ADDR_SEG3 belongs to a neighbouring slice
			if (hdr_r[PSCL_ADDR_HI:PSCL_ADDR_LO] == PSCL_ADDR_SEG1)
				seg1_r <= hdr_nxt;
			if (hdr_r[PSCL_ADDR_HI:PSCL_ADDR_LO] == PSCL_ADDR_SEG2)
				seg2_r <= hdr_nxt;
		end
	end

	assign seg1_amplitude_o = seg1_r[PSCL_AMP_W-1:0];
	assign seg2_amplitude_o = seg2_r[PSCL_AMP_W-1:0];

	// *****************************************
	// Segment sequencer
	// *****************************************
	pscl_seg_seq u_seq (
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.arb_mode_i(arb_mode_i),
		.pulse_start_i(pulse_start_i),
		.seg_tick_i(seg_tick_i),
		.seg_words_i({seg3_to_8_i, seg2_r[PSCL_AMP_W-1:0], seg1_r[PSCL_AMP_W-1:0]}),
		.arb_active_o(arb_active_o),
		.seg_index_o(seg_index_o),
		.seg_amp_o(seg_amp_o)
	);

	// Sign and magnitude split for the pulse DAC
	assign seg_sign_o = seg_amp_o[PSCL_AMP_SIGN];
	assign seg_mag_o = seg_amp_o[PSCL_AMP_SIGN-1:0];
endmodule : pscl_regs
`default_nettype wire

// >>> src/pscl_seg_seq.sv
// Arbitrary transmit pulse segment sequencer.
// Assumes seg_tick_i pulses eight times per master clock period.
`timescale 1ns/100ps
`default_nettype none
module pscl_seg_seq
	import pscl_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic arb_mode_i,
	input wire logic pulse_start_i,
	input wire logic seg_tick_i,
	input wire logic [PSCL_SEGS*PSCL_AMP_W-1:0] seg_words_i,
	output logic arb_active_o,
	output logic [2:0] seg_index_o,
	output logic [PSCL_AMP_W-1:0] seg_amp_o
);
	typedef enum logic {PSCL_SEQ_IDLE, PSCL_SEQ_RUN} pscl_seq_t;
	pscl_seq_t state_r;
	logic [2:0] seg_r;
	logic [PSCL_AMP_W-1:0] amp_r;

	// *****************************************
	// Segment walk
	// *****************************************
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_r <= PSCL_SEQ_IDLE;
			seg_r <= 3'h0;
		end
		else
		begin
			case (state_r)
				PSCL_SEQ_IDLE:
				begin
					seg_r <= 3'h0;
					if (arb_mode_i && pulse_start_i)
						state_r <= PSCL_SEQ_RUN;
				end
				PSCL_SEQ_RUN:
				begin
					if (!arb_mode_i)
					begin
						state_r <= PSCL_SEQ_IDLE;
						seg_r <= 3'h0;
					end
					else if (seg_tick_i)
					begin
						seg_r <= seg_r + 3'h1;
						if (seg_r == PSCL_LAST_SEG)
							state_r <= PSCL_SEQ_IDLE;
					end
				end
				default:
				begin
					state_r <= PSCL_SEQ_IDLE;
				end
			endcase
		end
	end

	// Outside a pulse, or out of arbitrary mode, the amplitude rests at zero
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
			amp_r <= '0;
		else if (state_r == PSCL_SEQ_RUN && arb_mode_i)
			amp_r <= seg_words_i[seg_r*PSCL_AMP_W +: PSCL_AMP_W];
		else
			amp_r <= '0;
	end

	assign arb_active_o = (state_r == PSCL_SEQ_RUN);
	assign seg_index_o = seg_r;
	assign seg_amp_o = amp_r;
endmodule : pscl_seg_seq
`default_nettype wire
